// ===== include/sar_adc_pkg.sv
// constants, layouts and types of the converter control sequencer
// Notes on behaviour
// - the resolution select bit picks 10-bit with four sample-and-hold channels (default) or 12-bit with one.
// - peak rates are 1.1 Msps in 10-bit mode and 500 ksps in 12-bit mode.
// - in 10-bit mode up to four inputs are sampled at the same instant, one per sample-and-hold channel.
// - in 12-bit mode there is no simultaneous sampling and simultaneous sample is unimplemented, reading zero.
// - the input multiplexer offers up to 13 analog inputs, 0 to 12, the count set by the package variant.
// - the converter runs on in sleep and idle, and idle stop chooses whether idle halts it.
// - module on, bit 15 of control one, enables the converter when set and holds it off when clear.
// - output format at bits 9-8 picks one of four result presentations for both resolutions.
// - with trigger select zero software clears sample active to convert, with codes 1, 2, 3 or 5 the device clears it.
// - with auto sample set the device restarts sampling and sets sample active after a conversion completes.
// - done is set at conversion end and cleared at a new start, software may only clear it without side effect.
package sar_adc_pkg;
  localparam logic [7:0]  CTL_ONE_ADDR    = 8'h00;
  localparam logic [7:0]  CTL_TWO_ADDR    = 8'h04;
  localparam logic [7:0]  BUF_BASE_ADDR   = 8'h40;
  localparam int          BUF_WORDS       = 16;
  localparam int          ON_BIT          = 15;
  localparam int          IDLE_STOP_BIT   = 13;
  localparam int          RES_BIT         = 10;
  localparam int          FMT_LSB         = 8;
  localparam int          TRIG_LSB        = 5;
  localparam int          SIMULTANEOUS_SAMPLE_BIT      = 3;
  localparam int          AUTO_SAMPLE_BIT        = 2;
  localparam int          SAMPLE_ACTIVE_BIT        = 1;
  localparam int          DONE_BIT        = 0;
  localparam int          SHCNT_LSB       = 8;
  localparam int          CHSEL_LSB       = 0;
  localparam logic [15:0] CTL_ONE_RESET   = 16'h0000;
  localparam int          NUM_INPUTS      = 13;
  localparam int          CLK_KHZ         = 125000;
  localparam int          RATE10_KSPS     = 1100;
  localparam int          RATE12_KSPS     = 500;
  // least period per conversion, rounded up
  localparam int          CONV10_CYCLES   = (CLK_KHZ + RATE10_KSPS - 1) / RATE10_KSPS;
  localparam int          CONV12_CYCLES   = (CLK_KHZ + RATE12_KSPS - 1) / RATE12_KSPS;

  typedef enum logic [2:0] {
    TRIG_MANUAL = 3'h0, TRIG_PIN = 3'h1, TRIG_TIMER = 3'h2, TRIG_PWM_A = 3'h3, TRIG_PWM_B = 3'h5
  } trig_code_t;

  typedef enum logic [1:0] {
    FMT_UINT = 2'h0, FMT_SINT = 2'h1, FMT_UFRAC = 2'h2, FMT_SFRAC = 2'h3
  } fmt_code_t;

  typedef struct packed {
    logic       module_on;
    logic       idle_stop;
    logic       resolution_select;
    logic [1:0] output_format;
    logic [2:0] trigger_select;
    logic       simultaneous_sample;
    logic       auto_sample;
  } ctl_t;

  typedef struct packed {
    logic ext_pin;
    logic timer_cmp;
    logic pwm_a;
    logic pwm_b;
  } trig_in_t;
endpackage

// ===== src/sar_adc_control_sequencer.sv
// apb-controlled sequencer of the successive-approximation converter
`timescale 1ns/1ps
module sar_adc_control_sequencer #(
  parameter int NUM_INPUTS = sar_adc_pkg::NUM_INPUTS
) (
  input  wire logic                         pclk,          // 125 MHz
  input  wire logic                         presetn,       // async, active low
  input  wire logic                         psel,          // apb select
  input  wire logic                         penable,       // apb access phase
  input  wire logic                         pwrite,        // apb direction
  input  wire logic [7:0]                   paddr,         // apb byte address
  input  wire logic [31:0]                  pwdata,        // apb write data
  output logic      [31:0]                  prdata,        // apb read data
  output logic                              pready,        // apb ready
  output logic                              pslverr,       // unmapped access
  input  wire logic [NUM_INPUTS-1:0][11:0]  analog_in,     // digitised input levels
  input  wire sar_adc_pkg::trig_in_t        trig_in,       // conversion trigger sources
  input  wire logic                         cpu_idle,      // processor in idle
  output logic                              sample_active, // sample-and-hold sampling
  output logic                              conv_busy      // conversion running
);
  typedef enum {ST_OFF, ST_WAIT, ST_SAMPLE, ST_CONVERT} state_t;

  state_t              state_reg;
  sar_adc_pkg::ctl_t   ctl_reg;
  logic                sample_active_reg;
  logic                done_reg;
  logic [1:0]          shcnt_reg;
  logic [3:0]          chsel_reg;
  logic [7:0]          cnt_reg;
  logic [1:0]          ch_reg;
  logic [3:0]          ptr_reg;
  logic                pin_q_reg;
  localparam int       BUF_W = sar_adc_pkg::BUF_WORDS;
  logic [3:0][11:0]    held_reg;
  logic [BUF_W-1:0][15:0] buf_reg;
  logic [31:0]         rd_word;

  logic        wr_en, rd_en, hit_ctl1, hit_ctl2, hit_buf;
  logic        trig_fire, sw_end, halt, start_conv, conv_step, conv_last;
  logic [1:0]  last_ch;
  logic [7:0]  conv_len;
  logic [11:0] chan_level;

  assign wr_en    = psel && penable && pwrite;
  assign rd_en    = psel && !pwrite;
  assign hit_ctl1 = paddr == sar_adc_pkg::CTL_ONE_ADDR;
  assign hit_ctl2 = paddr == sar_adc_pkg::CTL_TWO_ADDR;
  assign hit_buf  = paddr[7:6] == sar_adc_pkg::BUF_BASE_ADDR[7:6] && paddr[1:0] == 2'h0;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !(hit_ctl1 || hit_ctl2 || hit_buf);

  assign halt = ctl_reg.idle_stop && cpu_idle;

  always_comb begin
    case (sar_adc_pkg::trig_code_t'(ctl_reg.trigger_select))
      sar_adc_pkg::TRIG_PIN:   trig_fire = trig_in.ext_pin && !pin_q_reg;
      sar_adc_pkg::TRIG_TIMER: trig_fire = trig_in.timer_cmp;
      sar_adc_pkg::TRIG_PWM_A: trig_fire = trig_in.pwm_a;
      sar_adc_pkg::TRIG_PWM_B: trig_fire = trig_in.pwm_b;
      default:                 trig_fire = 1'b0;
    endcase
  end

  assign sw_end = wr_en && hit_ctl1 && !pwdata[sar_adc_pkg::SAMPLE_ACTIVE_BIT]
                  && ctl_reg.trigger_select == 3'h0;
  assign start_conv = state_reg == ST_SAMPLE && !halt && (sw_end || trig_fire);

  assign last_ch  = ctl_reg.resolution_select ? 2'h0 : (shcnt_reg[1] ? 2'h3 : {1'b0, shcnt_reg[0]});
  assign conv_len = ctl_reg.resolution_select ? 8'(sar_adc_pkg::CONV12_CYCLES)
                                              : 8'(sar_adc_pkg::CONV10_CYCLES);
  assign conv_step = state_reg == ST_CONVERT && !halt && cnt_reg == 8'h00;
  assign conv_last = conv_step && ch_reg == last_ch;

  always_comb begin
    chan_level = 12'h000;
    if (ch_reg == 2'h0) begin
      if (32'(chsel_reg) < NUM_INPUTS) chan_level = analog_in[chsel_reg];
    end else if (32'(ch_reg) < NUM_INPUTS) begin
      chan_level = analog_in[ch_reg];
    end
  end

  function automatic logic [15:0] format_result(input logic [11:0] d, input logic res12, input logic [1:0] f);
    logic [15:0] r;
    r = 16'h0000;
    if (res12) begin
      case (sar_adc_pkg::fmt_code_t'(f))
        sar_adc_pkg::FMT_UINT:  r = {4'h0, d};
        sar_adc_pkg::FMT_SINT:  r = {{5{~d[11]}}, d[10:0]};
        sar_adc_pkg::FMT_UFRAC: r = {d, 4'h0};
        default:                r = {~d[11], d[10:0], 4'h0};
      endcase
    end else begin
      case (sar_adc_pkg::fmt_code_t'(f))
        sar_adc_pkg::FMT_UINT:  r = {6'h00, d[9:0]};
        sar_adc_pkg::FMT_SINT:  r = {{7{~d[9]}}, d[8:0]};
        sar_adc_pkg::FMT_UFRAC: r = {d[9:0], 6'h00};
        default:                r = {~d[9], d[8:0], 6'h00};
      endcase
    end
    return r;
  endfunction

  // control register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_reg   <= '0;
      shcnt_reg <= 2'h0;
      chsel_reg <= 4'h0;
    end else if (wr_en && hit_ctl1) begin
      ctl_reg.module_on   <= pwdata[sar_adc_pkg::ON_BIT];
      ctl_reg.idle_stop   <= pwdata[sar_adc_pkg::IDLE_STOP_BIT];
      ctl_reg.output_format  <= pwdata[sar_adc_pkg::FMT_LSB +: 2];
      ctl_reg.trigger_select <= pwdata[sar_adc_pkg::TRIG_LSB +: 3];
      ctl_reg.auto_sample    <= pwdata[sar_adc_pkg::AUTO_SAMPLE_BIT];
      if (!ctl_reg.module_on)
        ctl_reg.resolution_select <= pwdata[sar_adc_pkg::RES_BIT];
      ctl_reg.simultaneous_sample <= pwdata[sar_adc_pkg::SIMULTANEOUS_SAMPLE_BIT]
        && !(ctl_reg.module_on ? ctl_reg.resolution_select : pwdata[sar_adc_pkg::RES_BIT]);
    end else if (wr_en && hit_ctl2) begin
      shcnt_reg <= pwdata[sar_adc_pkg::SHCNT_LSB +: 2];
      chsel_reg <= pwdata[sar_adc_pkg::CHSEL_LSB +: 4];
    end
  end

  // sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_OFF;
      sample_active_reg  <= 1'b0;
      cnt_reg   <= 8'h00;
      ch_reg    <= 2'h0;
    end else if (!ctl_reg.module_on) begin
      state_reg <= ST_OFF;
      sample_active_reg  <= 1'b0;
      ch_reg    <= 2'h0;
    end else begin
      case (state_reg)
        ST_OFF: begin
          state_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          if (ctl_reg.auto_sample || (wr_en && hit_ctl1 && pwdata[sar_adc_pkg::SAMPLE_ACTIVE_BIT])) begin
            state_reg <= ST_SAMPLE;
            sample_active_reg  <= 1'b1;
          end
        end
        ST_SAMPLE: begin
          if (start_conv) begin
            state_reg <= ST_CONVERT;
            sample_active_reg  <= 1'b0;
            ch_reg    <= 2'h0;
            cnt_reg   <= conv_len - 8'h01;
          end
        end
        ST_CONVERT: begin
          if (halt) begin
            cnt_reg <= cnt_reg;
          end else if (conv_last) begin
            state_reg <= ctl_reg.auto_sample ? ST_SAMPLE : ST_WAIT;
            sample_active_reg  <= ctl_reg.auto_sample;
          end else if (conv_step) begin
            ch_reg  <= ch_reg + 2'h1;
            cnt_reg <= conv_len - 8'h01;
          end else begin
            cnt_reg <= cnt_reg - 8'h01;
          end
        end
        default: state_reg <= ST_OFF;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_reg <= '0;
    end else if (start_conv && ctl_reg.simultaneous_sample) begin
      for (int i = 0; i < 4; i++) held_reg[i] <= (i < NUM_INPUTS) ?
        ((i == 0 && 32'(chsel_reg) < NUM_INPUTS) ? analog_in[chsel_reg] : analog_in[i]) : 12'h000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
    end else if (conv_last) begin
      done_reg <= 1'b1;
    end else if (start_conv || (wr_en && hit_ctl1 && !pwdata[sar_adc_pkg::DONE_BIT])) begin
      done_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_reg <= '0;
      ptr_reg <= 4'h0;
    end else if (!ctl_reg.module_on) begin
      ptr_reg <= 4'h0;
    end else if (conv_step) begin
      buf_reg[ptr_reg] <= format_result(ctl_reg.simultaneous_sample ? held_reg[ch_reg] : chan_level,
                                        ctl_reg.resolution_select, ctl_reg.output_format);
      ptr_reg <= ptr_reg + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pin_q_reg <= 1'b0;
    else          pin_q_reg <= trig_in.ext_pin;
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    if (rd_en && hit_ctl1) begin
      rd_word[sar_adc_pkg::ON_BIT]        = ctl_reg.module_on;
      rd_word[sar_adc_pkg::IDLE_STOP_BIT] = ctl_reg.idle_stop;
      rd_word[sar_adc_pkg::RES_BIT]       = ctl_reg.resolution_select;
      rd_word[sar_adc_pkg::FMT_LSB +: 2]  = ctl_reg.output_format;
      rd_word[sar_adc_pkg::TRIG_LSB +: 3] = ctl_reg.trigger_select;
      rd_word[sar_adc_pkg::SIMULTANEOUS_SAMPLE_BIT]    = ctl_reg.simultaneous_sample;
      rd_word[sar_adc_pkg::AUTO_SAMPLE_BIT]      = ctl_reg.auto_sample;
      rd_word[sar_adc_pkg::SAMPLE_ACTIVE_BIT]      = sample_active_reg;
      rd_word[sar_adc_pkg::DONE_BIT]      = done_reg;
    end else if (rd_en && hit_ctl2) begin
      rd_word[sar_adc_pkg::SHCNT_LSB +: 2] = shcnt_reg;
      rd_word[sar_adc_pkg::CHSEL_LSB +: 4] = chsel_reg;
    end else if (rd_en && hit_buf) begin
      rd_word[15:0] = buf_reg[paddr[5:2]];
    end
  end

  // read word captured in setup, shown through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else          prdata <= (psel && !penable) ? rd_word : 32'h0000_0000;
  end

  assign sample_active = sample_active_reg;
  assign conv_busy     = state_reg == ST_CONVERT;

  sequence s_conv_start;
    start_conv;
  endsequence
  sequence s_conv_running;
    conv_busy && !sample_active_reg;
  endsequence

  a_off_holds_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !ctl_reg.module_on |=> !conv_busy && !sample_active_reg) else $error("converter active while off");
  a_trig_clears_sample_active: assert property (@(posedge pclk) disable iff (!presetn)
    s_conv_start |=> s_conv_running) else $error("sample bit not cleared at conversion start");
  a_reserved_no_start: assert property (@(posedge pclk) disable iff (!presetn)
    state_reg == ST_SAMPLE && ctl_reg.trigger_select inside {3'h4, 3'h6, 3'h7} && ctl_reg.module_on
    |=> !conv_busy) else $error("reserved trigger started a conversion");
  a_done_follows: assert property (@(posedge pclk) disable iff (!presetn)
    conv_last |=> done_reg) else $error("done not set after conversion");
  a_done_clears: assert property (@(posedge pclk) disable iff (!presetn)
    s_conv_start |=> !done_reg) else $error("done not cleared at conversion start");
  a_simultaneous_sample_zero: assert property (@(posedge pclk) disable iff (!presetn)
    ctl_reg.resolution_select |-> !ctl_reg.simultaneous_sample) else $error("simultaneous set in 12-bit");
  a_auto_restart: assert property (@(posedge pclk) disable iff (!presetn)
    conv_last && ctl_reg.auto_sample && ctl_reg.module_on |=> sample_active_reg && state_reg == ST_SAMPLE)
    else $error("auto sample did not restart");
  a_conv_period: assert property (@(posedge pclk) disable iff (!presetn)
    s_conv_start ##1 (!halt && ctl_reg.module_on && ctl_reg.resolution_select)[*8] |-> !done_reg)
    else $error("conversion ended too early");
  a_idle_freeze: assert property (@(posedge pclk) disable iff (!presetn)
    conv_busy && halt && ctl_reg.module_on |=> $stable(cnt_reg) && $stable(ptr_reg))
    else $error("conversion advanced while idle stopped");
  a_buffer_write: assert property (@(posedge pclk) disable iff (!presetn)
    conv_step && ctl_reg.module_on |=> ptr_reg == $past(ptr_reg) + 4'h1) else $error("result not stored");
endmodule // sar_adc_control_sequencer

// ===== sim/tb_sar_adc_control_sequencer.sv
// self-checking testbench of the converter control sequencer
`timescale 1ns/1ps
module tb_sar_adc_control_sequencer;
  localparam int         N      = sar_adc_pkg::NUM_INPUTS;
  localparam logic [7:0] CTL1   = sar_adc_pkg::CTL_ONE_ADDR;
  localparam logic [7:0] CTL2   = sar_adc_pkg::CTL_TWO_ADDR;
  localparam logic [7:0] BUF    = sar_adc_pkg::BUF_BASE_ADDR;
  localparam int         LIMIT  = 20000;
  logic                  pclk = 1'b0;
  logic                  presetn = 1'b0;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [7:0]            paddr = 8'h00;
  logic [31:0]           pwdata = 32'h0;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic [N-1:0][11:0]    ain = '0;
  sar_adc_pkg::trig_in_t trig = '0;
  logic                  cpu_idle = 1'b0;
  logic                  sample_active;
  logic                  conv_busy;
  int                    error_cnt = 0;
  int                    n_checks = 0;
  int                    cycles = 0;
  int                    ptr = 0;
  int                    sel = 0;
  logic [31:0]           rv;
  logic                  err;
  logic [31:0]           rnd = 32'd79843;

  sar_adc_control_sequencer #(.NUM_INPUTS(N)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .analog_in(ain), .trig_in(trig),
    .cpu_idle(cpu_idle), .sample_active(sample_active), .conv_busy(conv_busy));

  always #4 pclk = ~pclk;

  task automatic results;
    if (error_cnt == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles >= LIMIT) begin
      error_cnt++;
      results();
    end
  end

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // expected result word per output format
  function automatic logic [15:0] fmt(input logic [11:0] d, input bit r12, input int f);
    int b;
    int v;
    b = r12 ? 12 : 10;
    case (f)
      0: v = int'(d);
      1: v = int'(d) - (1 << (b - 1));
      2: v = int'(d) << (16 - b);
      default: v = (int'(d) ^ (1 << (b - 1))) << (16 - b);
    endcase
    return v[15:0];
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    check(nm, e, rv);
  endtask

  task automatic new_inputs;
    for (int i = 0; i < N; i++) begin
      rnd = lfsr(rnd);
      ain[i] <= rnd[11:0];
    end
    rnd = lfsr(rnd);
    sel = int'(rnd[3:0]) % N;
  endtask

  task automatic pulse(input logic [3:0] t);
    @(posedge pclk);
    trig <= sar_adc_pkg::trig_in_t'(t);
    @(posedge pclk);
    trig <= '0;
  endtask

  task automatic no_conv;
    repeat (4) begin
      @(negedge pclk);
      check("conv_busy", 32'h0, {31'h0, conv_busy});
      check("still_sampling", 32'h1, {31'h0, sample_active});
    end
  endtask

  // waits out one conversion, then checks status and buffer words
  task automatic conv(input int nch, input bit r12, input int f, input logic [31:0] expc);
    int c;
    int idx;
    logic [11:0] d;
    c = 0;
    for (int k = 0; k < 3000; k++) begin
      @(posedge pclk);
      if (conv_busy === 1'b1) c++;
      else if (c > 0) break;
    end
    check("conv_cycles", 32'(nch * (r12 ? sar_adc_pkg::CONV12_CYCLES : sar_adc_pkg::CONV10_CYCLES)), 32'(c));
    rd(CTL1, expc, "ctl_one_status");
    for (int ch = 0; ch < nch; ch++) begin
      idx = (ch == 0) ? sel : ch;
      d = r12 ? ain[idx] : {2'b00, ain[idx][9:0]};
      rd(BUF + 8'(4 * ptr), {16'h0000, fmt(d, r12, f)}, "result");
      ptr = (ptr + 1) % 16;
    end
  endtask

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(CTL1, 32'h0, "ctl_one_reset");
    rd(CTL2, 32'h0, "ctl_two_reset");
    rd(8'h20, 32'h0, "unmapped_read");
    check("unmapped_err", 32'h1, {31'h0, err});
    wr(CTL1, 32'h7fff);
    rd(CTL1, 32'h27e4, "ctl_one_12bit");
    wr(CTL1, 32'h0008);
    rd(CTL1, 32'h0008, "ctl_one_10bit");
    wr(CTL1, 32'h8000);
    wr(CTL1, 32'h8400);
    rd(CTL1, 32'h8000, "resolution_locked");
    for (int f = 0; f < 4; f++) begin
      new_inputs();
      wr(CTL2, 32'(sel));
      wr(CTL1, 32'h8002 | (f << 8));
      rd(CTL1, 32'h8002 | (f << 8), "sampling");
      wr(CTL1, 32'h8000 | (f << 8));
      conv(1, 1'b0, f, 32'h8001 | (f << 8));
    end
    wr(CTL1, 32'h8001);
    rd(CTL1, 32'h8001, "done_write_one");
    wr(CTL1, 32'h8000);
    rd(CTL1, 32'h8000, "done_clear");
    new_inputs();
    wr(CTL2, 32'h0200 | sel);
    wr(CTL1, 32'h800a);
    wr(CTL1, 32'h8008);
    conv(4, 1'b0, 0, 32'h8009);
    wr(CTL1, 32'h0);
    ptr = 0;
    for (int i = 0; i < 3; i++) begin
      wr(CTL1, 32'h8000 | ((i == 0 ? 4 : (i == 1 ? 6 : 7)) << 5));
      wr(CTL1, 32'h8002 | ((i == 0 ? 4 : (i == 1 ? 6 : 7)) << 5));
      pulse(4'b1111);
      no_conv();
      wr(CTL1, 32'h0);
    end
    for (int i = 0; i < 3; i++) begin
      new_inputs();
      wr(CTL2, 32'(sel));
      wr(CTL1, 32'h8000 | ((i == 0 ? 1 : (i == 1 ? 3 : 5)) << 5));
      wr(CTL1, 32'h8002 | ((i == 0 ? 1 : (i == 1 ? 3 : 5)) << 5));
      pulse(i == 0 ? 4'b1000 : (i == 1 ? 4'b0010 : 4'b0001));
      conv(1, 1'b0, 0, 32'h8001 | ((i == 0 ? 1 : (i == 1 ? 3 : 5)) << 5));
    end
    wr(CTL1, 32'h0);
    ptr = 0;
    wr(CTL1, 32'h0640);
    wr(CTL1, 32'ha640);
    wr(CTL1, 32'ha642);
    cpu_idle <= 1'b1;
    pulse(4'b0100);
    no_conv();
    cpu_idle <= 1'b0;
    wr(CTL1, 32'h0640);
    new_inputs();
    // no interrupt flag in this block, so setup has nothing to clear
    wr(CTL2, 32'(sel));
    wr(CTL1, 32'h8640);
    wr(CTL1, 32'h8642);
    pulse(4'b0100);
    @(negedge pclk);
    check("busy_on_trigger", 32'h1, {31'h0, conv_busy});
    check("sample_ended", 32'h0, {31'h0, sample_active});
    conv(1, 1'b1, 2, 32'h8641);
    wr(CTL1, 32'h0);
    ptr = 0;
    new_inputs();
    wr(CTL2, 32'(sel));
    wr(CTL1, 32'h8044);
    cpu_idle <= 1'b1;
    repeat (2) @(posedge pclk);
    pulse(4'b0100);
    conv(1, 1'b0, 0, 32'h8047);
    cpu_idle <= 1'b0;
    results();
  end
endmodule // tb_sar_adc_control_sequencer
